// ==== logic/sem_host_pkg.sv ====
/*
  Constants for the semaphore port controller: pin widths, command codes,
  timing figures and the cycle counts derived from them.
  Assumes a 25 MHz system clock; all times are converted to whole cycles here.
*/
`default_nettype none
package sem_host_pkg;
  // Cycles needed to cover a time, rounded up, never below one
  function automatic int ns_to_cyc(input int ns, input int period);
    int c;
    c = (ns + period - 1) / period;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cyc

  localparam int CLK_PERIOD_NS = 40; // System clock period
  localparam int T_WR_NS = 50; // Least write strobe width
  localparam int T_RD_NS = 55; // Longest read access time
  localparam int T_GAP_NS = 40; // Least deselect time between accesses
  localparam int SYNC_CYC = 4; // Three flops plus the agree stage
  localparam int WR_CYC = ns_to_cyc(T_WR_NS, CLK_PERIOD_NS);
  localparam int RD_CYC = ns_to_cyc(T_RD_NS, CLK_PERIOD_NS) + SYNC_CYC;
  localparam int GAP_CYC = ns_to_cyc(T_GAP_NS, CLK_PERIOD_NS);

  localparam int FLAG_NUM = 8; // Eight flags in the semaphore space
  localparam int IDX_W = 3; // Flag index width, low address bits
  localparam int ADDR_W = 14; // Full address width of the port
  localparam int DATA_W = 16; // Port data width
  localparam int CNT_W = 4; // Phase counter width

  // Command codes on the user side
  localparam logic [1:0] OP_INIT = 2'h0;
  localparam logic [1:0] OP_ACQ = 2'h1;
  localparam logic [1:0] OP_REL = 2'h2;
  localparam logic [1:0] OP_POLL = 2'h3;

  localparam logic [7:0] OWNED_RST = 8'h00; // Nothing held after reset
  localparam logic [2:0] IDX_LAST = 3'h7; // Last flag swept by init

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WSET,
    ST_WRITE,
    ST_WEND,
    ST_READ,
    ST_GAP
  } state_t;
endpackage : sem_host_pkg
`default_nettype wire

// ==== logic/pin_sync.sv ====
/*
  Three-flop synchroniser for a bus of pin inputs with a two-of-two agree
  filter. Assumes the inputs are asynchronous to sys_clk_in.
*/
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 16
) (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] s1_r; // Metastability catcher, read only by s2_r
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] out_r;
  logic [WIDTH-1:0] agree; // Bits where stages two and three match
  logic [WIDTH-1:0] out_nxt;

  assign agree = ~(s2_r ^ s3_r);
  // A bit only moves once it has been stable for two samples
  assign out_nxt = (agree & s2_r) | (~agree & out_r);

  // Shift chain and filtered output
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      out_r <= '0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      out_r <= out_nxt;
    end
  end

  assign sync_out = out_r;
endmodule : pin_sync
`default_nettype wire

// ==== logic/sem_host.sv ====
/*
  Controller for one port of a dual-port semaphore flag space. It takes
  init, acquire, release and poll commands and runs write/read pin cycles.
  Assumes the far device is asynchronous and that only this module drives
  the semaphore pins of its port; the data bus is resolved outside.
*/
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Init writes one to every flag
// - Claim is write zero then read zero
// - Owner releases by writing one
// - Failed claim withdrawn by writing one
// - Only three low address bits select flag
module sem_host (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic cmd_valid_in,
  input wire logic [1:0] cmd_op_in,
  input wire logic [sem_host_pkg::IDX_W-1:0] cmd_idx_in,
  output logic cmd_ready_out,
  output logic done_out,
  output logic granted_out,
  output logic denied_out,
  output logic bad_read_out,
  output logic [sem_host_pkg::FLAG_NUM-1:0] owned_out,
  output logic flag_space_select_n_out,
  output logic oe_n_out,
  output logic we_n_out,
  output logic [sem_host_pkg::ADDR_W-1:0] addr_out,
  output logic [sem_host_pkg::DATA_W-1:0] data_out,
  output logic data_oe_out,
  input wire logic [sem_host_pkg::DATA_W-1:0] data_in
);
  localparam int DW = sem_host_pkg::DATA_W;
  localparam int FN = sem_host_pkg::FLAG_NUM;
  localparam int IW = sem_host_pkg::IDX_W;
  localparam int CW = sem_host_pkg::CNT_W;
  localparam logic [CW-1:0] WR_LOAD = CW'(sem_host_pkg::WR_CYC - 1);
  localparam logic [CW-1:0] RD_LOAD = CW'(sem_host_pkg::RD_CYC - 1);
  localparam logic [CW-1:0] GAP_LOAD = CW'(sem_host_pkg::GAP_CYC - 1);

  sem_host_pkg::state_t state_r, state_nxt; // Pin cycle sequencer
  logic [CW-1:0] cnt_r, cnt_nxt; // Phase length counter
  logic [1:0] op_r, op_nxt; // Command in progress
  logic [IW-1:0] idx_r, idx_nxt; // Flag being accessed
  logic wval_r, wval_nxt; // Value written to the flag
  logic [FN-1:0] owned_r, owned_nxt; // Flags this side believes it holds
  logic ready_r, done_r, done_nxt;
  logic granted_r, granted_nxt;
  logic denied_r, denied_nxt;
  logic bad_r, bad_nxt;
  logic sem_n_r, oe_n_r, we_n_r, doe_r;
  logic [DW-1:0] rd_sync; // Filtered data bus
  logic cnt_zero; // Phase over
  logic rd_zero; // Read shows the flag held by this side
  logic rd_one; // Read shows the flag not ours
  logic init_more; // Init sweep has flags left

  // Data pins cross from the far device's timing into ours
  pin_sync #(.WIDTH(DW)) u_sync (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .pin_in(data_in),
    .sync_out(rd_sync)
  );

  assign cnt_zero = (cnt_r == '0);
  // A flag value is spread over the whole bus; anything else is a bad read
  assign rd_zero = (rd_sync == '0);
  assign rd_one = (&rd_sync);
  assign init_more = (op_r == sem_host_pkg::OP_INIT) && (idx_r != sem_host_pkg::IDX_LAST);

  // Sequencer: every access ends with the select released so the device
  // output latch is reopened for the next read
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    op_nxt = op_r;
    idx_nxt = idx_r;
    wval_nxt = wval_r;
    owned_nxt = owned_r;
    done_nxt = 1'b0;
    granted_nxt = granted_r;
    denied_nxt = denied_r;
    bad_nxt = bad_r;
    case (state_r)
      sem_host_pkg::ST_IDLE: begin
        if (cmd_valid_in) begin
          op_nxt = cmd_op_in;
          idx_nxt = cmd_idx_in;
          granted_nxt = 1'b0;
          denied_nxt = 1'b0;
          bad_nxt = 1'b0;
          case (cmd_op_in)
            sem_host_pkg::OP_INIT: begin
              // Device flags are not known until written; free them all
              idx_nxt = '0;
              wval_nxt = 1'b1;
              state_nxt = sem_host_pkg::ST_WSET;
            end
            sem_host_pkg::OP_ACQ: begin
              wval_nxt = 1'b0;
              state_nxt = sem_host_pkg::ST_WSET;
            end
            sem_host_pkg::OP_REL: begin
              // Serves both release and withdrawal of a failed claim
              wval_nxt = 1'b1;
              state_nxt = sem_host_pkg::ST_WSET;
            end
            default: begin
              cnt_nxt = RD_LOAD;
              state_nxt = sem_host_pkg::ST_READ;
            end
          endcase
        end
      end
      sem_host_pkg::ST_WSET: begin
        // One cycle of address setup before the strobe
        cnt_nxt = WR_LOAD;
        state_nxt = sem_host_pkg::ST_WRITE;
      end
      sem_host_pkg::ST_WRITE: begin
        cnt_nxt = cnt_r - 1'b1;
        if (cnt_zero) begin
          state_nxt = sem_host_pkg::ST_WEND;
        end
      end
      sem_host_pkg::ST_WEND: begin
        // Write-then-read: the verify read always follows the claim write
        if (op_r == sem_host_pkg::OP_ACQ) begin
          cnt_nxt = RD_LOAD;
          state_nxt = sem_host_pkg::ST_READ;
        end else begin
          cnt_nxt = GAP_LOAD;
          state_nxt = sem_host_pkg::ST_GAP;
        end
      end
      sem_host_pkg::ST_READ: begin
        cnt_nxt = cnt_r - 1'b1;
        if (cnt_zero) begin
          // Zero back means ours; one means the far side holds it
          granted_nxt = (op_r == sem_host_pkg::OP_ACQ) && rd_zero;
          denied_nxt = (op_r == sem_host_pkg::OP_ACQ) && rd_one;
          bad_nxt = !rd_zero && !rd_one;
          owned_nxt[idx_r] = rd_zero;
          cnt_nxt = GAP_LOAD;
          state_nxt = sem_host_pkg::ST_GAP;
        end
      end
      sem_host_pkg::ST_GAP: begin
        cnt_nxt = cnt_r - 1'b1;
        if (cnt_zero) begin
          if (init_more) begin
            idx_nxt = idx_r + 1'b1;
            state_nxt = sem_host_pkg::ST_WSET;
          end else begin
            if (op_r == sem_host_pkg::OP_INIT) begin
              owned_nxt = '0;
            end else if (op_r == sem_host_pkg::OP_REL) begin
              // The flag may pass straight to the far side, never to us
              owned_nxt[idx_r] = 1'b0;
            end
            done_nxt = 1'b1;
            state_nxt = sem_host_pkg::ST_IDLE;
          end
        end
      end
      default: begin
        state_nxt = sem_host_pkg::ST_IDLE;
      end
    endcase
  end

  // Pin levels follow the next state so they leave flops cleanly
  logic sem_n_nxt, oe_n_nxt, we_n_nxt, doe_nxt;
  assign sem_n_nxt = !(state_nxt == sem_host_pkg::ST_WSET ||
                       state_nxt == sem_host_pkg::ST_WRITE ||
                       state_nxt == sem_host_pkg::ST_READ);
  assign we_n_nxt = (state_nxt != sem_host_pkg::ST_WRITE);
  assign oe_n_nxt = (state_nxt != sem_host_pkg::ST_READ);
  // Data held one cycle past the strobe for hold time
  assign doe_nxt = (state_nxt == sem_host_pkg::ST_WSET ||
                    state_nxt == sem_host_pkg::ST_WRITE ||
                    state_nxt == sem_host_pkg::ST_WEND);

  // Control state
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      state_r <= sem_host_pkg::ST_IDLE;
      cnt_r <= '0;
      op_r <= sem_host_pkg::OP_INIT;
      idx_r <= '0;
      wval_r <= 1'b1;
      owned_r <= sem_host_pkg::OWNED_RST;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      op_r <= op_nxt;
      idx_r <= idx_nxt;
      wval_r <= wval_nxt;
      owned_r <= owned_nxt;
    end
  end

  // Status flags
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      ready_r <= 1'b1;
      done_r <= 1'b0;
      granted_r <= 1'b0;
      denied_r <= 1'b0;
      bad_r <= 1'b0;
    end else begin
      ready_r <= (state_nxt == sem_host_pkg::ST_IDLE);
      done_r <= done_nxt;
      granted_r <= granted_nxt;
      denied_r <= denied_nxt;
      bad_r <= bad_nxt;
    end
  end

  // Pin drivers; selects idle high
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      sem_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      we_n_r <= 1'b1;
      doe_r <= 1'b0;
    end else begin
      sem_n_r <= sem_n_nxt;
      oe_n_r <= oe_n_nxt;
      we_n_r <= we_n_nxt;
      doe_r <= doe_nxt;
    end
  end

  // Address: only the low bits matter, the rest held at zero
  logic [sem_host_pkg::ADDR_W-1:0] addr_r;
  logic [DW-1:0] wdata_r;
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      addr_r <= '0;
      wdata_r <= '0;
    end else begin
      addr_r <= {{(sem_host_pkg::ADDR_W-IW){1'b0}}, idx_nxt};
      wdata_r <= {{(DW-1){1'b0}}, wval_nxt};
    end
  end

  assign cmd_ready_out = ready_r;
  assign done_out = done_r;
  assign granted_out = granted_r;
  assign denied_out = denied_r;
  assign bad_read_out = bad_r;
  assign owned_out = owned_r;
  assign flag_space_select_n_out = sem_n_r;
  assign oe_n_out = oe_n_r;
  assign we_n_out = we_n_r;
  assign addr_out = addr_r;
  assign data_out = wdata_r;
  assign data_oe_out = doe_r;
endmodule : sem_host
`default_nettype wire

// ==== verif/sem_host_checker.sv ====
/* Assertions on the port pins of sem_host.
   Assumes one clock domain and the synchronous active-low reset. */
`timescale 1ns/10ps
`default_nettype none
module sem_host_checker (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic cmd_valid_in,
  input wire logic [1:0] cmd_op_in,
  input wire logic [sem_host_pkg::IDX_W-1:0] cmd_idx_in,
  input wire logic cmd_ready_out,
  input wire logic done_out,
  input wire logic granted_out,
  input wire logic denied_out,
  input wire logic bad_read_out,
  input wire logic [sem_host_pkg::FLAG_NUM-1:0] owned_out,
  input wire logic flag_space_select_n_out,
  input wire logic oe_n_out,
  input wire logic we_n_out,
  input wire logic [sem_host_pkg::ADDR_W-1:0] addr_out,
  input wire logic [sem_host_pkg::DATA_W-1:0] data_out,
  input wire logic data_oe_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  // Command accepted at this edge, split by kind
  wire logic take = cmd_valid_in && cmd_ready_out;
  wire logic take_acq = take && (cmd_op_in == sem_host_pkg::OP_ACQ);
  wire logic take_rel = take && (cmd_op_in == sem_host_pkg::OP_REL);
  wire logic take_poll = take && (cmd_op_in == sem_host_pkg::OP_POLL);
  wire logic take_init = take && (cmd_op_in == sem_host_pkg::OP_INIT);
  // Fixed latencies from the taking edge to the edge that sees done; init is
  // seven five-cycle flag writes plus a last one that also spends the done cycle
  a_acq_done_time: assert property (take_acq |-> ##12 done_out)
    else $error("acquire finished late");
  a_rel_done_time: assert property (take_rel |-> ##6 done_out)
    else $error("release finished late");
  a_poll_done_time: assert property (take_poll |-> ##8 done_out)
    else $error("poll finished late");
  a_init_done_time: assert property (take_init |-> ##41 done_out)
    else $error("init finished late");
  a_acq_write_zero: assert property (take_acq |-> ##3 (!we_n_out && data_oe_out && !data_out[0] && !flag_space_select_n_out))
    else $error("claim strobe does not write zero");
  a_rel_write_one: assert property (take_rel |-> ##3 (!we_n_out && data_out[0] && addr_out[2:0] == $past(cmd_idx_in, 3)))
    else $error("release strobe does not write one");
  a_addr_low_only: assert property (addr_out[13:3] == 11'h000)
    else $error("high address bits driven");
  a_data_bit_zero: assert property (data_out[15:1] == 15'h0000)
    else $error("upper write data bits driven");
  a_bus_no_fight: assert property (oe_n_out || (!data_oe_out && we_n_out))
    else $error("read overlaps own drive");
  a_verdict_single: assert property (!(granted_out && denied_out))
    else $error("granted and denied together");
  a_grant_owns: assert property ($rose(granted_out) |-> owned_out[addr_out[2:0]])
    else $error("grant without ownership");
  c_grant: cover property ($rose(granted_out));
  c_deny: cover property ($rose(denied_out));
  c_bad: cover property ($rose(bad_read_out));
endmodule : sem_host_checker
bind sem_host sem_host_checker u_checker (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
  .cmd_valid_in(cmd_valid_in), .cmd_op_in(cmd_op_in), .cmd_idx_in(cmd_idx_in),
  .cmd_ready_out(cmd_ready_out), .done_out(done_out), .granted_out(granted_out),
  .denied_out(denied_out), .bad_read_out(bad_read_out), .owned_out(owned_out),
  .flag_space_select_n_out(flag_space_select_n_out), .oe_n_out(oe_n_out),
  .we_n_out(we_n_out), .addr_out(addr_out), .data_out(data_out), .data_oe_out(data_oe_out));
`default_nettype wire

// ==== verif/sem_dev_model.sv ====
/* Behavioural flag space seen from the controller's port.
   Assumes the bench works the opposite port through the other_* pins. */
`timescale 1ns/10ps
`default_nettype none
module sem_dev_model (
  input wire logic sem_n_in,
  input wire logic oe_n_in,
  input wire logic we_n_in,
  input wire logic [13:0] addr_in,
  input wire logic [15:0] bus_in,
  input wire logic other_wr_in,
  input wire logic [2:0] other_idx_in,
  input wire logic other_val_in,
  input wire logic corrupt_in,
  output logic [15:0] dev_data_out
);
  logic [7:0] req_h = 8'ha5; // Junk at power-up, nobody clears it
  logic [7:0] req_o = 8'h3c; // Opposite side junk too
  logic [7:0] own_h = 8'h00; // Host side holds the flag
  logic [7:0] own_o = 8'h00; // Opposite side holds the flag
  logic [15:0] rd = 16'h0000; // Read latch, frozen while selected
  // Strobe takes bit zero, index from the low bits only
  always @(negedge we_n_in) if (!sem_n_in) req_h[addr_in[2:0]] = bus_in[0];
  // Opposite write lands as its strobe ends, when index and value have settled
  always @(negedge other_wr_in) req_o[other_idx_in] = other_val_in;
  // Release frees or hands over; host wins a tie, which keeps runs repeatable
  always @(req_h or req_o) begin
    for (int i = 0; i < 8; i++) begin
      if (own_h[i] && req_h[i]) own_h[i] = 1'b0;
      if (own_o[i] && req_o[i]) own_o[i] = 1'b0;
      if (!own_h[i] && !own_o[i]) begin
        own_h[i] = !req_h[i];
        own_o[i] = req_h[i] && !req_o[i];
      end
    end
  end
  // Latched when both selects go active, spread over all bits; the short
  // settle lets an address launched on the same clock edge arrive first
  always @(negedge oe_n_in or negedge sem_n_in) begin
    #1;
    if (!sem_n_in && !oe_n_in) rd = corrupt_in ? 16'h00ff : {16{!own_h[addr_in[2:0]]}};
  end
  // A released bus shows the inverse, never a stale match
  assign dev_data_out = (!sem_n_in && !oe_n_in) ? rd : ~rd;
endmodule : sem_dev_model
`default_nettype wire

// ==== verif/dual_port_semaphore_flags_bench.sv ====
/* Self-checking bench for sem_host against the flag space model.
   Assumes the 25 MHz clock and the fixed latencies of the hand-over. */
`timescale 1ns/10ps
`default_nettype none
module dual_port_semaphore_flags_bench;
  typedef struct {logic [1:0] op; logic [2:0] idx; int lat; logic g; logic d; logic own;} row_t;
  logic sys_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic cmd_valid_in = 1'b0;
  logic [1:0] cmd_op_in = 2'h0;
  logic [2:0] cmd_idx_in = 3'h0;
  logic o_wr = 1'b0; // Opposite port strobe
  logic [2:0] o_idx = 3'h0;
  logic o_val = 1'b1;
  logic corrupt = 1'b0; // Forces a mixed read
  logic ready, done, gr, dn, bad, sem_n, oe_n, we_n, doe;
  logic [7:0] owned;
  logic [13:0] addr;
  logic [15:0] dout, ddev;
  wire logic [15:0] bus = doe ? dout : ddev; // Resolved data pins
  int failures = 0;
  int samples_checked = 0;
  row_t rows [4] = '{'{sem_host_pkg::OP_ACQ, 3'h0, 12, 1'b1, 1'b0, 1'b1},
    '{sem_host_pkg::OP_ACQ, 3'h7, 12, 1'b1, 1'b0, 1'b1},
    '{sem_host_pkg::OP_REL, 3'h0, 6, 1'b0, 1'b0, 1'b0},
    '{sem_host_pkg::OP_REL, 3'h7, 6, 1'b0, 1'b0, 1'b0}};
  always #20 sys_clk_in = ~sys_clk_in;
  sem_host uut (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .cmd_valid_in(cmd_valid_in),
    .cmd_op_in(cmd_op_in), .cmd_idx_in(cmd_idx_in), .cmd_ready_out(ready), .done_out(done),
    .granted_out(gr), .denied_out(dn), .bad_read_out(bad), .owned_out(owned),
    .flag_space_select_n_out(sem_n), .oe_n_out(oe_n), .we_n_out(we_n), .addr_out(addr),
    .data_out(dout), .data_oe_out(doe), .data_in(bus));
  sem_dev_model dev (.sem_n_in(sem_n), .oe_n_in(oe_n), .we_n_in(we_n), .addr_in(addr),
    .bus_in(bus), .other_wr_in(o_wr), .other_idx_in(o_idx), .other_val_in(o_val),
    .corrupt_in(corrupt), .dev_data_out(ddev));
  // Counts every comparison, reports a miss at once
  task check(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      failures++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask : check
  task finish_test;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test
  // One command; a lost done counts and ends the run
  task run_cmd(input logic [1:0] op, input logic [2:0] idx, input int lat);
    int n;
    n = 0;
    @(negedge sys_clk_in);
    {cmd_valid_in, cmd_op_in, cmd_idx_in} = {1'b1, op, idx};
    @(negedge sys_clk_in);
    cmd_valid_in = 1'b0;
    while (done !== 1'b1 && n < 60) begin
      @(negedge sys_clk_in);
      n++;
    end
    if (n >= 60) begin
      check(1'b0, "no done");
      finish_test();
    end
    // Done is seen at the falling edge just before the rising edge lat
    check(n == lat - 1, "latency");
  endtask : run_cmd
  // Opposite port writes one flag
  task other_write(input logic [2:0] idx, input logic val);
    @(negedge sys_clk_in);
    {o_wr, o_idx, o_val} = {1'b1, idx, val};
    @(negedge sys_clk_in);
    o_wr = 1'b0;
  endtask : other_write
  initial begin
    repeat (16) @(negedge sys_clk_in);
    check(ready === 1'b1 && owned === 8'h00 && sem_n === 1'b1 && doe === 1'b0, "reset idle");
    nrst_in = 1'b1;
    $display("test reset done");
    for (int i = 0; i < 8; i++) other_write(i[2:0], 1'b1);
    run_cmd(sem_host_pkg::OP_INIT, 3'h0, 41);
    check(owned === 8'h00 && bad === 1'b0, "init state");
    $display("test init done");
    for (int i = 0; i < 4; i++) begin
      run_cmd(rows[i].op, rows[i].idx, rows[i].lat);
      check(gr === rows[i].g && dn === rows[i].d && owned[rows[i].idx] === rows[i].own, "row");
    end
    $display("test table done");
    other_write(3'h5, 1'b0);
    run_cmd(sem_host_pkg::OP_ACQ, 3'h5, 12);
    check(dn === 1'b1 && gr === 1'b0 && owned[5] === 1'b0, "lockout");
    other_write(3'h5, 1'b1);
    run_cmd(sem_host_pkg::OP_POLL, 3'h5, 8);
    check(owned[5] === 1'b1, "handover");
    run_cmd(sem_host_pkg::OP_REL, 3'h5, 6);
    $display("test handover done");
    other_write(3'h6, 1'b0);
    run_cmd(sem_host_pkg::OP_ACQ, 3'h6, 12);
    run_cmd(sem_host_pkg::OP_REL, 3'h6, 6);
    other_write(3'h6, 1'b1);
    run_cmd(sem_host_pkg::OP_POLL, 3'h6, 8);
    check(owned[6] === 1'b0 && bad === 1'b0, "withdraw");
    $display("test withdraw done");
    corrupt = 1'b1;
    run_cmd(sem_host_pkg::OP_POLL, 3'h1, 8);
    check(bad === 1'b1, "mixed read");
    corrupt = 1'b0;
    $display("test mixed read done");
    // Reset in the middle of a claim, after its write strobe has landed
    @(negedge sys_clk_in);
    {cmd_valid_in, cmd_op_in, cmd_idx_in} = {1'b1, sem_host_pkg::OP_ACQ, 3'h2};
    @(negedge sys_clk_in);
    cmd_valid_in = 1'b0;
    repeat (3) @(negedge sys_clk_in);
    nrst_in = 1'b0;
    repeat (4) @(negedge sys_clk_in);
    check(ready === 1'b1 && owned === 8'h00 && {sem_n, oe_n, we_n} === 3'b111
      && doe === 1'b0 && done === 1'b0 && gr === 1'b0, "mid reset");
    nrst_in = 1'b1;
    run_cmd(sem_host_pkg::OP_REL, 3'h2, 6);
    run_cmd(sem_host_pkg::OP_ACQ, 3'h2, 12);
    check(gr === 1'b1 && dn === 1'b0 && owned[2] === 1'b1, "claim after reset");
    run_cmd(sem_host_pkg::OP_REL, 3'h2, 6);
    check(owned[2] === 1'b0, "release after reset");
    $display("test mid reset done");
    finish_test();
  end
endmodule : dual_port_semaphore_flags_bench
`default_nettype wire
